// [igs_pkg.sv]
// Shared constants and types for the instruction group sequencer.
package igs_pkg;

  // Bundle layout: template in the low bits, then three slots upward.
  localparam int BUNDLE_W = 128;
  localparam int SLOT_W = 41;
  localparam int TMPL_W = 5;
  localparam int TMPL_LSB = 0;
  localparam int SLOT0_LSB = 5;
  localparam int NUM_SLOTS = 3;
  localparam logic [1:0] LAST_SLOT = 2'h2;

  // Qualifying predicate field sits in the low bits of every slot.
  localparam int QP_LSB = 0;
  localparam int QP_W = 6;
  localparam int PR_COUNT = 64;

  // General register file shape.
  localparam int GR_IDX_W = 7;
  localparam int GR_DEPTH = 128;
  localparam int GR_W = 64;

  // Addresses and reset values.
  localparam int IP_W = 64;
  localparam logic [63:0] RESET_IP = 64'h0000_0000_0000_0000;
  localparam logic [63:0] HANDLER_IP = 64'h0000_0000_0000_0400;
  localparam logic [63:0] BUNDLE_STEP = 64'h0000_0000_0000_0010;
  localparam logic [63:0] PR_RESET = 64'h0000_0000_0000_0001;
  localparam logic [7:0] GROUP_ID_RESET = 8'h00;

  // Fault code raised by the sequencer itself for an unusable template.
  localparam logic [7:0] EXC_BAD_TEMPLATE = 8'hFF;

  typedef enum logic [1:0] {
    IGS_S_LOAD = 2'b00,
    IGS_S_ISSUE = 2'b01,
    IGS_S_WAIT = 2'b10
  } igs_state_e;

  // One instruction handed to the execution side.
  typedef struct packed {
    logic valid;
    logic [SLOT_W-1:0] instr;
    logic [IP_W-1:0] ip;
    logic [1:0] slot;
    logic qp_val;
    logic grp_start;
    logic [7:0] grp_id;
  } igs_issue_s;

  // Completion report from the execution side.
  typedef struct packed {
    logic done;
    logic fault;
    logic [7:0] code;
    logic brk_b;
    logic taken;
    logic [IP_W-1:0] target;
    logic serialize;
    logic gr_we;
    logic [GR_IDX_W-1:0] gr_idx;
    logic [GR_W-1:0] gr_data;
    logic pr_we;
    logic [QP_W-1:0] pr_idx;
    logic pr_val;
  } igs_resp_s;

  // Precise exception report.
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [IP_W-1:0] ip;
    logic [1:0] slot;
  } igs_exc_s;

endpackage

// [igs_gr_file.sv]
// General register file with one write port and a registered read port.
`timescale 1ns/1ns
`default_nettype none
module igs_gr_file (
  input wire logic sys_clk, // Core clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic wr_en, // Write strobe.
  input wire logic [igs_pkg::GR_IDX_W-1:0] wr_idx, // Write index.
  input wire logic [igs_pkg::GR_W-1:0] wr_data, // Write data.
  input wire logic [igs_pkg::GR_IDX_W-1:0] rd_idx, // Read index.
  output logic [igs_pkg::GR_W-1:0] rd_data_ff // Read data, one cycle late.
);
  import igs_pkg::*;

  logic [GR_W-1:0] mem [GR_DEPTH];

  // Storage array; no reset so it maps onto plain memory.
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // Read before write: a same-cycle write shows up on the next read.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data_ff <= '0;
    end else begin
      rd_data_ff <= mem[rd_idx];
    end
  end

endmodule
`default_nettype wire

// [igs_sequencer.sv]
// Instruction group sequencer: fetch, slot order, groups and exceptions.
// Notes on behaviour
// RULE_01 - Lower bundle addresses come first in order.
// RULE_02 - Bundles are little-endian; template in byte zero.
// RULE_03 - Slots issue from slot zero to two.
// RULE_04 - Fetch, read, execute, update appear in order.
// RULE_05 - Group ends at stop, taken branch, branch fault.
// RULE_06 - Other breaks, checks, interruptions keep group open.
// RULE_07 - Flow targets never depend on pre-change instructions.
// RULE_08 - Serialize operations make later fetches see updates.
// RULE_09 - Groups read state after previous group updates.
// RULE_10 - Memory and table reads see earlier group updates.
// RULE_11 - Register reads see state before group updates.
// RULE_12 - False qualifying predicate suppresses reads and writes.
// RULE_13 - Code holds no register RAW or WAW in-group.
// RULE_14 - Implicit register accesses count like explicit ones.
// RULE_15 - Predicate zero ignores writes, always reads one.
// RULE_16 - Loads return latest earlier store to address.
// RULE_17 - Last store to an address wins.
// RULE_18 - Later store never alters earlier load data.
// RULE_19 - Table accesses order like memory within group.
// RULE_20 - Exceptions precise: earlier updated, later not.
// RULE_21 - Earliest faulting instruction is the one reported.
// RULE_22 - Pointer reads give own bundle address, serially.
// RULE_23 - Bundle holds three 41-bit slots above template.
// RULE_24 - Template value places stops after slots.
`timescale 1ns/1ns
`default_nettype none
module igs_sequencer (
  input wire logic sys_clk, // Core clock, 50 MHz.
  input wire logic rst, // Synchronous reset, active high.
  output logic fetch_req_ff, // Bundle fetch request, held until answered.
  output logic [igs_pkg::IP_W-1:0] fetch_addr_ff, // Bundle address.
  input wire logic fetch_valid, // Fetch data valid, one cycle.
  input wire logic [igs_pkg::BUNDLE_W-1:0] fetch_data, // Bundle bytes.
  output igs_pkg::igs_issue_s iss_ff, // Instruction issued to execution.
  input wire igs_pkg::igs_resp_s rsp, // Completion from execution.
  input wire logic [igs_pkg::GR_IDX_W-1:0] gr_rd_idx, // Register read index.
  output logic [igs_pkg::GR_W-1:0] gr_rd_data_ff, // Register read data.
  input wire logic [igs_pkg::QP_W-1:0] pr_rd_idx, // Predicate read index.
  output logic pr_rd_val_ff, // Predicate read value.
  output igs_pkg::igs_exc_s exc_ff, // Exception report, one-cycle pulse.
  output logic grp_end_ff // Instruction group ended, one-cycle pulse.
);
  import igs_pkg::*;

  // Stop positions per template; bit n set means a stop after slot n.
  function automatic logic [2:0] stop_mask(input logic [TMPL_W-1:0] t);
    logic [2:0] m;
    m = 3'h0;
    m[2] = t[0];
    m[1] = (t[4:1] == 4'h1);
    m[0] = (t[4:1] == 4'h5);
    return m;
  endfunction

  // Templates with no slot mapping cannot be executed.
  function automatic logic tmpl_reserved(input logic [TMPL_W-1:0] t);
    return (t == 5'h14) || (t == 5'h15) || (t == 5'h1A) ||
           (t == 5'h1B) || (t == 5'h1E) || (t == 5'h1F);
  endfunction

  // Predicate zero reads as one whatever the stored bit holds.
  function automatic logic pred_read(input logic [PR_COUNT-1:0] pr,
                                     input logic [QP_W-1:0] idx);
    return (idx == 6'h00) ? 1'b1 : pr[idx];
  endfunction

  // Slot n sits above the template and the lower slots.
  function automatic logic [SLOT_W-1:0] slot_field(
      input logic [BUNDLE_W-1:0] b, input logic [1:0] n);
    logic [SLOT_W-1:0] f;
    f = b[SLOT0_LSB +: SLOT_W];
    if (n == 2'h1) begin
      f = b[SLOT0_LSB + SLOT_W +: SLOT_W];
    end else if (n == 2'h2) begin
      f = b[SLOT0_LSB + 2*SLOT_W +: SLOT_W];
    end
    return f;
  endfunction

  igs_state_e state_ff;
  igs_state_e nxt_state;
  logic [IP_W-1:0] fa_ff;
  logic pf_valid_ff;
  logic [BUNDLE_W-1:0] pf_data_ff;
  logic [IP_W-1:0] pf_ip_ff;
  logic kill_ff;
  logic [BUNDLE_W-1:0] bnd_ff;
  logic [IP_W-1:0] bip_ff;
  logic [1:0] slot_ff;
  logic [7:0] grp_id_ff;
  logic grp_start_ff;
  logic [PR_COUNT-1:0] pr_ff;
  logic [TMPL_W-1:0] cur_tmpl;
  logic [TMPL_W-1:0] pf_tmpl;
  logic [2:0] cur_stops;
  logic [SLOT_W-1:0] cur_instr;
  logic take_pf;
  logic bad_tmpl;
  logic rsp_ok;
  logic commit;
  logic end_grp;
  logic redirect;
  logic [IP_W-1:0] redir_addr;
  logic gr_we;

  // Template lives in the lowest-addressed byte of the bundle.
  assign cur_tmpl = bnd_ff[TMPL_LSB +: TMPL_W]; // see RULE_02 see RULE_23
  assign pf_tmpl = pf_data_ff[TMPL_LSB +: TMPL_W]; // see RULE_02
  assign cur_stops = stop_mask(cur_tmpl); // see RULE_24
  assign cur_instr = slot_field(bnd_ff, slot_ff); // see RULE_23

  // Event decode for the bundle load and for the completion of a slot.
  assign take_pf = (state_ff == IGS_S_LOAD) && pf_valid_ff;
  assign bad_tmpl = take_pf && tmpl_reserved(pf_tmpl);
  assign rsp_ok = (state_ff == IGS_S_WAIT) && rsp.done;
  // A faulting instruction never updates state, so later ones see none.
  assign commit = rsp_ok && !rsp.fault && iss_ff.qp_val; // see RULE_20
  // Group ends at a stop or a taken branch, or at a branch-unit break
  // fault; a faulting branch is never taken. Other faults leave it open.
  assign end_grp = rsp_ok && (rsp.fault ? rsp.brk_b : // see RULE_06
                   (rsp.taken || cur_stops[slot_ff])); // see RULE_05
  assign redirect = bad_tmpl ||
                    (rsp_ok && (rsp.fault || rsp.taken || rsp.serialize));

  // Faults win over branches, branches over a plain refetch.
  always_comb begin
    redir_addr = bip_ff + BUNDLE_STEP; // see RULE_08
    if (bad_tmpl || (rsp_ok && rsp.fault)) begin
      redir_addr = HANDLER_IP;
    end else if (rsp_ok && rsp.taken) begin
      redir_addr = rsp.target;
    end
  end

  // Fetch engine with one bundle of prefetch. A redirect drops the
  // prefetch and marks an outstanding answer stale, so nothing fetched
  // before a flow change, and no bundle after the current one fetched
  // before a serializing update, is ever executed.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fetch_req_ff <= 1'b0;
      fetch_addr_ff <= RESET_IP;
      fa_ff <= RESET_IP;
      pf_valid_ff <= 1'b0;
      pf_data_ff <= '0;
      pf_ip_ff <= RESET_IP;
      kill_ff <= 1'b0;
    end else begin
      if (fetch_req_ff && fetch_valid) begin
        fetch_req_ff <= 1'b0;
        kill_ff <= 1'b0;
        if (!kill_ff && !redirect) begin
          pf_valid_ff <= 1'b1;
          pf_data_ff <= fetch_data;
          pf_ip_ff <= fetch_addr_ff;
          fa_ff <= fetch_addr_ff + BUNDLE_STEP; // see RULE_01
        end
      end else if (!fetch_req_ff && !pf_valid_ff && !redirect) begin
        fetch_req_ff <= 1'b1;
        fetch_addr_ff <= fa_ff;
      end
      if (take_pf) begin
        pf_valid_ff <= 1'b0;
      end
      if (redirect) begin
        fa_ff <= redir_addr; // see RULE_07 see RULE_08
        pf_valid_ff <= 1'b0;
        if (fetch_req_ff && !fetch_valid) begin
          kill_ff <= 1'b1;
        end
      end
    end
  end

  // Serial state machine: one instruction in flight at a time.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      IGS_S_LOAD: begin
        if (take_pf && !bad_tmpl) begin
          nxt_state = IGS_S_ISSUE;
        end
      end
      IGS_S_ISSUE: begin
        nxt_state = IGS_S_WAIT;
      end
      IGS_S_WAIT: begin
        if (rsp.done) begin
          if (rsp.fault || rsp.taken || (slot_ff == LAST_SLOT)) begin
            nxt_state = IGS_S_LOAD;
          end else begin
            nxt_state = IGS_S_ISSUE;
          end
        end
      end
      default: begin
        nxt_state = IGS_S_LOAD;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= IGS_S_LOAD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Current bundle, its address and the slot pointer.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bnd_ff <= '0;
      bip_ff <= RESET_IP;
      slot_ff <= 2'h0;
    end else if (take_pf) begin
      bnd_ff <= pf_data_ff;
      bip_ff <= pf_ip_ff; // see RULE_22
      slot_ff <= 2'h0; // see RULE_03
    end else if (rsp_ok && !rsp.fault && !rsp.taken &&
                 (slot_ff != LAST_SLOT)) begin
      slot_ff <= slot_ff + 2'h1; // see RULE_03
    end
  end

  // Group numbering; a flow change also opens a fresh dependency window.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      grp_id_ff <= GROUP_ID_RESET;
      grp_start_ff <= 1'b1;
      grp_end_ff <= 1'b0;
    end else begin
      grp_end_ff <= end_grp; // see RULE_05
      if (end_grp) begin
        grp_id_ff <= grp_id_ff + 8'h01;
      end
      // Set wins over the clear that issue performs.
      if (end_grp || redirect) begin
        grp_start_ff <= 1'b1; // see RULE_07
      end else if (state_ff == IGS_S_ISSUE) begin
        grp_start_ff <= 1'b0;
      end
    end
  end

  // Issue port. The pointer handed out is the bundle's own address even
  // though slots of one bundle share it, as serial execution would give.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      iss_ff <= '0;
    end else begin
      iss_ff.valid <= (state_ff == IGS_S_ISSUE); // see RULE_04
      if (state_ff == IGS_S_ISSUE) begin
        iss_ff.instr <= cur_instr; // see RULE_23
        iss_ff.ip <= bip_ff; // see RULE_22
        iss_ff.slot <= slot_ff;
        iss_ff.qp_val <= pred_read(pr_ff, // see RULE_12
            cur_instr[QP_LSB +: QP_W]);
        iss_ff.grp_start <= grp_start_ff;
        iss_ff.grp_id <= grp_id_ff;
      end
    end
  end

  // Exception report. Only one instruction is ever outstanding, so the
  // first fault seen is the earliest in program order; nothing after it
  // has been issued, which keeps the report precise.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      exc_ff <= '0;
    end else begin
      exc_ff.valid <= bad_tmpl || (rsp_ok && rsp.fault); // see RULE_21
      if (bad_tmpl) begin
        exc_ff.code <= EXC_BAD_TEMPLATE;
        exc_ff.ip <= pf_ip_ff;
        exc_ff.slot <= 2'h0;
      end else if (rsp_ok && rsp.fault) begin
        exc_ff.code <= rsp.code; // see RULE_20
        exc_ff.ip <= iss_ff.ip;
        exc_ff.slot <= iss_ff.slot;
      end
    end
  end

  // Predicate file. Writes to predicate zero are dropped. Commits are in
  // program order one at a time, so implicit and explicit writers alike
  // are seen by the next group; within a group legal code never reads
  // what it wrote, so it still sees the state before the group.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pr_ff <= PR_RESET;
      pr_rd_val_ff <= 1'b1;
    end else begin
      if (commit && rsp.pr_we && (rsp.pr_idx != 6'h00)) begin
        pr_ff[rsp.pr_idx] <= rsp.pr_val; // see RULE_15 see RULE_09 see RULE_14
      end
      pr_rd_val_ff <= pred_read(pr_ff, pr_rd_idx); // see RULE_15 see RULE_11
    end
  end

  // Register writes commit as each instruction completes. Because the
  // code carries no in-group RAW or WAW on registers, committing early
  // is invisible to the group; a same-group reader of a later writer's
  // target gets the old value since the writer has not yet issued.
  // The trade is no overlap between instructions, bought for precision.
  assign gr_we = commit && rsp.gr_we; // see RULE_11 see RULE_13 see RULE_09

  // Loads, stores and table accesses are performed by the execution side
  // strictly one after another in slot order, so a load sees the latest
  // earlier store, the last store stays, and a later store cannot reach
  // back into a completed load.
  // see RULE_10 see RULE_16 see RULE_17 see RULE_18 see RULE_19

  igs_gr_file igs_gr_file_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(gr_we),
    .wr_idx(rsp.gr_idx),
    .wr_data(rsp.gr_data),
    .rd_idx(gr_rd_idx),
    .rd_data_ff(gr_rd_data_ff)
  );

  // Breaks outside the branch unit, checks and other faults redirect but
  // do not end the group; the group id therefore carries on.
  // see RULE_06

endmodule
`default_nettype wire

// [igs_chk_asserts.sv]
// Port-level checker for the instruction group sequencer.
`timescale 1ns/1ns
`default_nettype none
module igs_chk
  import igs_pkg::*;
(
  input wire logic sys_clk, // Core clock.
  input wire logic rst, // Reset.
  input wire logic fetch_req_ff, // Fetch request.
  input wire logic [IP_W-1:0] fetch_addr_ff, // Fetch address.
  input wire logic fetch_valid, // Fetch answer.
  input wire igs_pkg::igs_issue_s iss_ff, // Issue.
  input wire igs_pkg::igs_resp_s rsp, // Completion.
  input wire logic [QP_W-1:0] pr_rd_idx, // Predicate index.
  input wire logic pr_rd_val_ff, // Predicate value.
  input wire igs_pkg::igs_exc_s exc_ff, // Exception.
  input wire logic grp_end_ff // Group end.
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic seen_ff;
  logic pend_ff;
  logic [1:0] lslot_ff;
  logic [63:0] lip_ff;
  logic [63:0] tgt_ff;
  // Remember the last issue and where a redirect must land next.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seen_ff <= 1'b0;
      pend_ff <= 1'b0;
    end else if (iss_ff.valid) begin
      seen_ff <= 1'b1;
      pend_ff <= 1'b0;
      lslot_ff <= iss_ff.slot;
      lip_ff <= iss_ff.ip;
    end else if (rsp.done && (rsp.fault || rsp.taken && iss_ff.qp_val)) begin
      pend_ff <= 1'b1;
      tgt_ff <= rsp.fault ? HANDLER_IP : rsp.target;
    end else if (exc_ff.valid && exc_ff.code == EXC_BAD_TEMPLATE) begin
      pend_ff <= 1'b1;
      tgt_ff <= HANDLER_IP;
    end
  end
  req_hold_a: assert property (
    fetch_req_ff && !fetch_valid |=> fetch_req_ff && $stable(fetch_addr_ff))
    else $error("Fetch request dropped or moved.");
  req_drop_a: assert property (
    fetch_req_ff && fetch_valid |=> !fetch_req_ff)
    else $error("Fetch request kept after answer.");
  pr_zero_a: assert property (
    pr_rd_idx == 6'h00 |=> pr_rd_val_ff) else $error("Predicate zero read 0.");
  iss_pulse_a: assert property (
    iss_ff.valid |=> !iss_ff.valid) else $error("Issue longer than a pulse.");
  slot_seq_a: assert property (
    iss_ff.valid && seen_ff && !iss_ff.grp_start |->
    (iss_ff.slot == lslot_ff + 2'h1 && iss_ff.ip == lip_ff) ||
    (iss_ff.slot == 2'h0 && lslot_ff == LAST_SLOT &&
    iss_ff.ip == lip_ff + BUNDLE_STEP)) else $error("Issue out of order.");
  exc_src_a: assert property (
    exc_ff.valid |-> ($past(rsp.done && rsp.fault) &&
    exc_ff.code == $past(rsp.code) && exc_ff.ip == $past(iss_ff.ip) &&
    exc_ff.slot == $past(iss_ff.slot)) || (!$past(rsp.done) &&
    exc_ff.code == EXC_BAD_TEMPLATE && exc_ff.slot == 2'h0))
    else $error("Exception not precise.");
  end_src_a: assert property (
    grp_end_ff |-> $past(rsp.done)) else $error("Group end without done.");
  taken_end_a: assert property (
    rsp.done && rsp.taken && iss_ff.qp_val && !rsp.fault |=> grp_end_ff)
    else $error("Taken branch kept group open.");
  brk_end_a: assert property (
    rsp.done && rsp.fault && rsp.brk_b |=> grp_end_ff && exc_ff.valid)
    else $error("Branch break kept group open.");
  soft_fault_a: assert property (
    rsp.done && rsp.fault && !rsp.brk_b |=> !grp_end_ff && exc_ff.valid)
    else $error("Ordinary fault ended group.");
  redirect_a: assert property (
    iss_ff.valid && pend_ff |-> iss_ff.grp_start && iss_ff.ip == tgt_ff &&
    iss_ff.slot == 2'h0) else $error("Redirect landed wrongly.");
  taken_c: cover property (rsp.done && rsp.taken && iss_ff.qp_val);
  brk_c: cover property (grp_end_ff && exc_ff.valid);
  fault_c: cover property (exc_ff.valid && !grp_end_ff);
  bad_tmpl_c: cover property (exc_ff.valid && exc_ff.code == EXC_BAD_TEMPLATE);
endmodule
bind igs_sequencer igs_chk igs_chk_inst (.sys_clk, .rst, .fetch_req_ff,
  .fetch_addr_ff, .fetch_valid, .iss_ff, .rsp, .pr_rd_idx, .pr_rd_val_ff,
  .exc_ff, .grp_end_ff);
`default_nettype wire

// [igs_imem_model.sv]
// Instruction memory model that answers bundle fetches.
`timescale 1ns/1ns
`default_nettype none
module igs_imem_model (
  input wire logic sys_clk, // Core clock.
  input wire logic rst, // Reset.
  input wire logic fetch_req_ff, // Fetch request.
  input wire logic [63:0] fetch_addr_ff, // Bundle address.
  output logic fetch_valid, // One-cycle answer.
  output logic [127:0] fetch_data // Bundle word.
);
  logic [127:0] mem [0:127];
  logic [1:0] dly = 2'h0;
  initial fetch_valid = 1'b0;
  initial fetch_data = '0;
  // Delay of 0 to 3 cycles follows the previous fetch address, so prompt and slow answers
  // both occur; idle data toggles so a stale bundle never looks valid.
  always @(posedge sys_clk) begin
    if (rst || fetch_valid || !fetch_req_ff) begin
      fetch_valid <= 1'b0;
      fetch_data <= ~fetch_data;
      dly <= fetch_addr_ff[5:4];
    end else if (dly != 2'h0) begin
      dly <= dly - 2'h1;
      fetch_data <= ~fetch_data;
    end else begin
      fetch_valid <= 1'b1;
      fetch_data <= mem[fetch_addr_ff[10:4]]; // Whole bundle, byte 0 low.
    end
  end
endmodule
`default_nettype wire

// [igs_sequencer_tb.sv]
// Self-checking bench for the instruction group sequencer.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
module igs_sequencer_tb;
  import igs_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic fetch_req_ff, fetch_valid, pr_rd_val_ff, grp_end_ff, estart;
  logic [63:0] fetch_addr_ff, gr_rd_data_ff, pr, eip;
  logic [127:0] fetch_data;
  logic [127:0] img [0:127];
  logic [63:0] gr [0:7];
  logic [7:0] gv, egid, wmask;
  logic [6:0] gr_rd_idx;
  logic [5:0] pr_rd_idx;
  logic [1:0] eslot;
  igs_issue_s iss_ff;
  igs_resp_s rsp;
  igs_exc_s exc_ff;
  int err_count = 0;
  int checked = 0;
  int seed = 50174;
  always #10 sys_clk = ~sys_clk;
  igs_sequencer igs_sequencer_inst (.sys_clk(sys_clk), .rst(rst),
    .fetch_req_ff(fetch_req_ff), .fetch_addr_ff(fetch_addr_ff),
    .fetch_valid(fetch_valid), .fetch_data(fetch_data), .iss_ff(iss_ff),
    .rsp(rsp), .gr_rd_idx(gr_rd_idx), .gr_rd_data_ff(gr_rd_data_ff),
    .pr_rd_idx(pr_rd_idx), .pr_rd_val_ff(pr_rd_val_ff), .exc_ff(exc_ff),
    .grp_end_ff(grp_end_ff));
  igs_imem_model igs_imem_model_inst (.sys_clk(sys_clk), .rst(rst),
    .fetch_req_ff(fetch_req_ff), .fetch_addr_ff(fetch_addr_ff),
    .fetch_valid(fetch_valid), .fetch_data(fetch_data));
  // Stop after slot 2 on odd templates, slot 1 on 02/03, slot 0 on 0A/0B.
  function automatic logic stop_after(input logic [4:0] t,
                                      input logic [1:0] s);
    return (s == 2'h2 && t[0]) || (s == 2'h1 && t[4:1] == 4'h1) ||
      (s == 2'h0 && t[4:1] == 4'h5);
  endfunction
  // Templates 14, 15, 1A, 1B, 1E and 1F map no units and must trap.
  function automatic logic tmpl_bad(input logic [4:0] t);
    return t == 5'h14 || t == 5'h15 || t == 5'h1A || t == 5'h1B ||
      t[4:1] == 4'hF;
  endfunction
  task end_sim;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One instruction: check the issue, complete it, check the aftermath.
  task automatic step(input int kind);
    logic [127:0] b;
    logic [40:0] ins;
    logic [31:0] rv;
    logic q, tk, flt, stp, ser, ge;
    igs_resp_s r;
    int n;
    b = img[eip[10:4]];
    // A reserved template traps before any slot of its bundle issues.
    if (eslot == 2'h0 && tmpl_bad(b[4:0])) begin
      for (n = 0; n < 300 && exc_ff.valid !== 1'b1; n++) @(negedge sys_clk);
      `CHK({exc_ff.code, exc_ff.ip, exc_ff.slot}, {EXC_BAD_TEMPLATE, eip, 2'h0})
      `CHK(grp_end_ff, 1'b0)
      eip = HANDLER_IP;
      estart = 1'b1;
      wmask = '0;
      b = img[eip[10:4]];
    end
    ins = b[5 + 41 * eslot +: 41];
    q = pr[ins[5:0]];
    flt = kind == 1 || kind == 2;
    tk = kind == 0 && q;
    ser = kind == 5 && q;
    stp = stop_after(b[4:0], eslot);
    ge = flt ? (kind == 2) : tk || stp;
    for (n = 0; n < 300 && iss_ff.valid !== 1'b1; n++) @(negedge sys_clk);
    `CHK(iss_ff.ip, eip)
    `CHK(iss_ff.slot, eslot)
    `CHK(iss_ff.instr, ins)
    `CHK(iss_ff.qp_val, q)
    `CHK(iss_ff.grp_start, estart)
    `CHK(iss_ff.grp_id, egid)
    `CHK(pr_rd_val_ff, pr[pr_rd_idx])
    if (gv[gr_rd_idx[2:0]]) `CHK(gr_rd_data_ff, gr[gr_rd_idx[2:0]])
    rv = $random(seed);
    r = '0;
    r.done = 1'b1;
    r.fault = flt;
    r.brk_b = kind == 2;
    r.taken = tk;
    r.code = rv[7:0];
    r.target = {53'h0, rv[22:16], 4'h0};
    r.serialize = ser;
    // No second write to a register inside one dependency window.
    r.gr_we = !wmask[rv[10:8]];
    r.gr_idx = {4'h0, rv[10:8]};
    r.gr_data = {$random(seed), $random(seed)};
    r.pr_we = kind == 3 || kind == 4;
    r.pr_idx = kind == 4 ? 6'h00 : {4'h0, rv[13:12]};
    r.pr_val = rv[14];
    @(posedge sys_clk);
    rsp <= r;
    gr_rd_idx <= r.gr_idx;
    pr_rd_idx <= r.pr_idx;
    @(posedge sys_clk);
    rsp <= '0;
    @(negedge sys_clk);
    `CHK(grp_end_ff, ge)
    `CHK(exc_ff.valid, flt)
    if (flt) `CHK({exc_ff.code, exc_ff.ip, exc_ff.slot}, {r.code, eip, eslot})
    // Faulting or predicated-off work leaves no trace in the state model.
    if (!flt && q) begin
      if (r.gr_we) begin
        gr[r.gr_idx[2:0]] = r.gr_data;
        gv[r.gr_idx[2:0]] = 1'b1;
        wmask[r.gr_idx[2:0]] = 1'b1;
      end
      if (r.pr_we && r.pr_idx != 6'h00) pr[r.pr_idx] = r.pr_val;
    end
    if (ge) egid = egid + 8'h01;
    // A group end or any flow change opens a fresh dependency window.
    estart = flt || tk || stp || ser;
    if (estart) wmask = '0;
    if (flt || tk) begin
      eip = flt ? HANDLER_IP : r.target;
      eslot = 2'h0;
    end else if (eslot == LAST_SLOT) begin
      eip = eip + BUNDLE_STEP;
      eslot = 2'h0;
    end else eslot = eslot + 2'h1;
  endtask
  initial begin
    rsp = '0;
    gr_rd_idx = '0;
    pr_rd_idx = '0;
    gv = '0;
    egid = GROUP_ID_RESET;
    wmask = '0;
    pr = PR_RESET;
    eip = RESET_IP;
    eslot = 2'h0;
    estart = 1'b1;
    // Predicate fields kept to 0..3 so the written predicates matter.
    for (int i = 0; i < 128; i++) begin
      img[i] = {$random(seed), $random(seed), $random(seed), $random(seed)};
      for (int s = 0; s < 3; s++) img[i][7 + 41 * s +: 4] = 4'h0;
      img[i][4:0] = i % 32 == 22 ? {4'hD, i[5]} :
        i % 4 == 1 ? {4'h5, i[2]} : 5'h13 & img[i][4:0];
      igs_imem_model_inst.mem[i] = img[i];
    end
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    `CHK({fetch_req_ff, pr_rd_val_ff}, 2'b01)
    @(negedge sys_clk);
    `CHK({fetch_req_ff, fetch_addr_ff}, {1'b1, RESET_IP})
    repeat (400) step({$random(seed)} % 7);
    end_sim;
  end
  // A step takes well under 50 cycles, so this span only trips on a hang.
  initial begin
    #(20 * 20000);
    err_count++;
    end_sim;
  end
endmodule
`default_nettype wire
